// [core/gcap_defines.svh]
// constants of the auxiliary control port: offsets, fields, reset values, timing
// assumes a 100 MHz system clock and a 32-bit register port with byte addresses
`ifndef GCAP_DEFINES_SVH
`define GCAP_DEFINES_SVH

// ==========================================================
// timing
`define GCAP_CLK_HZ 100000000
`define GCAP_FILT_MS 50
`define GCAP_FILT_CYC (`GCAP_CLK_HZ / 1000 * `GCAP_FILT_MS)
`define GCAP_ALARM_S 1
`define GCAP_ALARM_CYC (`GCAP_CLK_HZ * `GCAP_ALARM_S)
`define GCAP_GM_MS 20
`define GCAP_GM_CYC (`GCAP_CLK_HZ / 1000 * `GCAP_GM_MS)

// ==========================================================
// register byte offsets
`define GCAP_ACTION_OFS 8'h00
`define GCAP_PRESET_OFS 8'h04
`define GCAP_OMASK0_OFS 8'h08
`define GCAP_ATIME_OFS 8'h14
`define GCAP_DLY0_OFS 8'h18
`define GCAP_STATUS_OFS 8'h2C
`define GCAP_ISTAT_OFS 8'h30
`define GCAP_IMASK_OFS 8'h34

// ==========================================================
// field layout
`define GCAP_ACT_W 3
`define GCAP_PSEL_W 8
`define GCAP_EV_N 9
`define GCAP_DLY_N 5
`define GCAP_DLY_W 17
`define GCAP_IRQ_N 7
`define GCAP_AT_H_LSB 16
`define GCAP_AT_M_LSB 8
`define GCAP_AT_S_LSB 0
`define GCAP_ST_ALARM_LSB 4
`define GCAP_ST_ALARM_ACT_LSB 8

// ==========================================================
// reset values
`define GCAP_ACTION_RST 12'h000
`define GCAP_OMASK_RST 9'h000
`define GCAP_IMASK_RST 7'h00

`endif

// [core/gcap_pkg.sv]
// types of the auxiliary control port
// assumes the constants header is on the include path
`include "gcap_defines.svh"

package gcap_pkg;

  // ==========================================================
  // input actions
  typedef enum logic [2:0] {
    GCAP_ACT_NONE = 3'h0,
    GCAP_ACT_PROG_RESET = 3'h1,
    GCAP_ACT_REACQUIRE = 3'h2,
    GCAP_ACT_JAM_SYNC = 3'h3,
    GCAP_ACT_NTP_UPDATE = 3'h4,
    GCAP_ACT_RECALL = 3'h5
  } gcap_action_t;

endpackage : gcap_pkg

// [core/gcap_port.sv]
// auxiliary control port: filtered command inputs, selectable alarm outputs
// assumes one 100 MHz clock, command pins asynchronous, status inputs on clk
`timescale 1ns/1ns
`default_nettype none
`include "gcap_defines.svh"

module gcap_port #(
  parameter int FILT_CYC = `GCAP_FILT_CYC,
  parameter int ALARM_CYC = `GCAP_ALARM_CYC,
  parameter int GM_CYC = `GCAP_GM_CYC,
  parameter int SEC_CYC = `GCAP_CLK_HZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // pins
  input wire logic [3:0] cmd_in_n,
  output logic [2:0] alarm_out_n,
  // status from the instrument
  input wire logic hw_fault,
  input wire logic first_supply_indicator_red,
  input wire logic second_supply_indicator_red,
  input wire logic ref_red,
  input wire logic ref_yellow,
  input wire logic time_red,
  input wire logic time_yellow,
  input wire logic [1:0] timing_leader_role,
  input wire logic [4:0] prog_hours,
  input wire logic [5:0] prog_minutes,
  input wire logic [5:0] prog_seconds,
  input wire logic tod_src_internal,
  // commands to the instrument
  output logic prog_time_reset,
  output logic satellite_positioning_receiver_reset,
  output logic jam_sync,
  output logic ntp_update_req,
  output logic preset_recall,
  output logic [7:0] preset_sel
);

  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int AW = $clog2(ALARM_CYC + 1);
  localparam int GW = $clog2(GM_CYC + 1);
  localparam int SW = $clog2(SEC_CYC + 1);
  localparam int DN = `GCAP_DLY_N;
  localparam int DWD = `GCAP_DLY_W;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] filt;
    logic [3:0][FW-1:0] filt_cnt;
    logic [3:0][2:0] action;
    logic [3:0][7:0] preset;
    logic [2:0][8:0] omask;
    logic [4:0] at_h;
    logic [5:0] at_m;
    logic [5:0] at_s;
    logic [DN-1:0][DWD-1:0] dly;
    logic [DN-1:0][SW-1:0] dly_sub;
    logic [DN-1:0][DWD-1:0] dly_sec;
    logic [DN-1:0] lvl;
    logic match_q;
    logic [AW-1:0] at_cnt;
    logic [1:0] leader_q;
    logic [1:0][GW-1:0] gm_cnt;
    logic [6:0] istat;
    logic [6:0] imask;
    logic [31:0] rdata;
    logic [4:0] cmd;
    logic [7:0] psel;
    logic [2:0] alarm_n;
    logic irq;
  } gcap_state_t;

  gcap_state_t st;
  gcap_state_t next_st;

  // ==========================================================
  // helpers
  function automatic logic gcap_hit(input logic [8:0] mask, input logic [8:0] ev);
    gcap_hit = |(mask & ev);
  endfunction : gcap_hit

  function automatic logic gcap_at(input logic [7:0] addr, input logic [7:0] base, input int k);
    gcap_at = (addr == 8'(base + 8'(4 * k)));
  endfunction : gcap_at

  logic [DN-1:0] cond;
  logic [8:0] ev;
  logic match;

  assign cond = {time_yellow, time_red, ref_yellow, ref_red, hw_fault};
  assign match = (prog_hours == st.at_h) && (prog_minutes == st.at_m) && (prog_seconds == st.at_s);
  assign ev = {st.gm_cnt[1] != '0, st.gm_cnt[0] != '0, st.at_cnt != '0, st.lvl[4:1],
               first_supply_indicator_red | second_supply_indicator_red, st.lvl[0]};

  // ==========================================================
  // next state
  always_comb begin
    logic [3:0] rise;
    logic [6:0] iset;
    logic [31:0] rd;
    next_st = st;
    rise = 4'h0;
    iset = 7'h00;
    rd = 32'h0000_0000;
    next_st.cmd = 5'h00;
    next_st.rdata = 32'h0000_0000;
    next_st.sync1 = cmd_in_n;
    next_st.sync2 = st.sync1;
    for (int i = 0; i < 4; i++) begin
      if (~st.sync2[i] == st.filt[i]) begin
        next_st.filt_cnt[i] = '0;
      end else if (st.filt_cnt[i] == FW'(FILT_CYC - 1)) begin
        next_st.filt_cnt[i] = '0;
        next_st.filt[i] = ~st.sync2[i];
        rise[i] = ~st.sync2[i];
      end else begin
        next_st.filt_cnt[i] = st.filt_cnt[i] + FW'(1);
      end
    end
    // per-input action, lowest input wins preset select
    for (int i = 3; i >= 0; i--) begin
      if (rise[i]) begin
        case (gcap_pkg::gcap_action_t'(st.action[i]))
          gcap_pkg::GCAP_ACT_PROG_RESET: next_st.cmd[0] = 1'b1;
          gcap_pkg::GCAP_ACT_REACQUIRE: next_st.cmd[1] = 1'b1;
          gcap_pkg::GCAP_ACT_JAM_SYNC: next_st.cmd[2] = 1'b1;
          gcap_pkg::GCAP_ACT_NTP_UPDATE: next_st.cmd[3] = tod_src_internal;
          gcap_pkg::GCAP_ACT_RECALL: begin
            next_st.cmd[4] = 1'b1;
            next_st.psel = st.preset[i];
          end
          default: ;
        endcase
      end
    end
    iset[3:0] = rise;
    for (int d = 0; d < DN; d++) begin
      if (!cond[d]) begin
        next_st.dly_sub[d] = '0;
        next_st.dly_sec[d] = '0;
        next_st.lvl[d] = 1'b0;
      end else if (st.dly[d] == '0 || st.dly_sec[d] >= st.dly[d]) begin
        next_st.lvl[d] = 1'b1;
      end else if (st.dly_sub[d] == SW'(SEC_CYC - 1)) begin
        next_st.dly_sub[d] = '0;
        next_st.dly_sec[d] = st.dly_sec[d] + DWD'(1);
      end else begin
        next_st.dly_sub[d] = st.dly_sub[d] + SW'(1);
      end
    end
    next_st.match_q = match;
    if (match && !st.match_q) begin
      next_st.at_cnt = AW'(ALARM_CYC);
      iset[4] = 1'b1;
    end else if (st.at_cnt != '0) begin
      next_st.at_cnt = st.at_cnt - AW'(1);
    end
    next_st.leader_q = timing_leader_role;
    for (int g = 0; g < 2; g++) begin
      if (st.leader_q[g] && !timing_leader_role[g]) begin
        next_st.gm_cnt[g] = GW'(GM_CYC);
        iset[5 + g] = 1'b1;
      end else if (st.gm_cnt[g] != '0) begin
        next_st.gm_cnt[g] = st.gm_cnt[g] - GW'(1);
      end
    end
    for (int o = 0; o < 3; o++) begin
      next_st.alarm_n[o] = ~gcap_hit(st.omask[o], ev);
    end
    // register writes
    if (reg_wr) begin
      if (reg_addr == `GCAP_ACTION_OFS) begin
        next_st.action = reg_wdata[11:0];
      end else if (reg_addr == `GCAP_PRESET_OFS) begin
        next_st.preset = reg_wdata;
      end else if (reg_addr == `GCAP_ATIME_OFS) begin
        next_st.at_h = reg_wdata[`GCAP_AT_H_LSB +: 5];
        next_st.at_m = reg_wdata[`GCAP_AT_M_LSB +: 6];
        next_st.at_s = reg_wdata[`GCAP_AT_S_LSB +: 6];
      end else if (reg_addr == `GCAP_IMASK_OFS) begin
        next_st.imask = reg_wdata[6:0];
      end
      for (int o = 0; o < 3; o++) begin
        if (gcap_at(reg_addr, `GCAP_OMASK0_OFS, o)) begin
          next_st.omask[o] = reg_wdata[8:0];
        end
      end
      for (int d = 0; d < DN; d++) begin
        if (gcap_at(reg_addr, `GCAP_DLY0_OFS, d)) begin
          next_st.dly[d] = reg_wdata[DWD-1:0];
        end
      end
    end
    // sticky events, set wins over write-one clear
    if (reg_wr && reg_addr == `GCAP_ISTAT_OFS) begin
      next_st.istat = (st.istat & ~reg_wdata[6:0]) | iset;
    end else begin
      next_st.istat = st.istat | iset;
    end
    next_st.irq = |(next_st.istat & next_st.imask);
    // register reads
    if (reg_rd) begin
      if (reg_addr == `GCAP_ACTION_OFS) begin
        rd = {20'h00000, st.action};
      end else if (reg_addr == `GCAP_PRESET_OFS) begin
        rd = st.preset;
      end else if (reg_addr == `GCAP_ATIME_OFS) begin
        rd = {11'h000, st.at_h, 2'h0, st.at_m, 2'h0, st.at_s};
      end else if (reg_addr == `GCAP_STATUS_OFS) begin
        rd = {24'h000000, ev[0] | ev[1], ~st.alarm_n, st.filt};
        rd[`GCAP_ST_ALARM_ACT_LSB +: 9] = ev;
      end else if (reg_addr == `GCAP_ISTAT_OFS) begin
        rd = {25'h0000000, st.istat};
      end else if (reg_addr == `GCAP_IMASK_OFS) begin
        rd = {25'h0000000, st.imask};
      end
      for (int o = 0; o < 3; o++) begin
        if (gcap_at(reg_addr, `GCAP_OMASK0_OFS, o)) begin
          rd = {23'h000000, st.omask[o]};
        end
      end
      for (int d = 0; d < DN; d++) begin
        if (gcap_at(reg_addr, `GCAP_DLY0_OFS, d)) begin
          rd = {15'h0000, st.dly[d]};
        end
      end
      next_st.rdata = rd;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.sync1 <= 4'hF;
      st.sync2 <= 4'hF;
      st.alarm_n <= 3'h7;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign irq = st.irq;
  assign alarm_out_n = st.alarm_n;
  assign prog_time_reset = st.cmd[0];
  assign satellite_positioning_receiver_reset = st.cmd[1];
  assign jam_sync = st.cmd[2];
  assign ntp_update_req = st.cmd[3];
  assign preset_recall = st.cmd[4];
  assign preset_sel = st.psel;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_filt_len;
    ce && (st.filt[0] != next_st.filt[0]) |-> st.filt_cnt[0] == FW'(FILT_CYC - 1);
  endproperty
  a_filt_len: assert property (p_filt_len) else $error("filter switched early");

  property p_idle_high;
    ce && (st.omask[0] == 9'h000) |=> alarm_out_n[0];
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("output low with nothing enabled");

  property p_none_quiet;
    ce && st.filt[1] != next_st.filt[1] && next_st.filt[1] && st.action == 12'h000 |=> st.cmd == 5'h00;
  endproperty
  a_none_quiet: assert property (p_none_quiet) else $error("action none fired");

  property p_prog_reset;
    ce && !st.filt[0] && next_st.filt[0] && st.action[0] == 3'h1 |=> prog_time_reset ##1 !prog_time_reset;
  endproperty
  a_prog_reset: assert property (p_prog_reset) else $error("program reset not a single pulse");

  property p_ntp_gate;
    ce && !tod_src_internal |=> !ntp_update_req;
  endproperty
  a_ntp_gate: assert property (p_ntp_gate) else $error("refresh without internal source");

  property p_or;
    ce && gcap_hit(st.omask[2], ev) |=> !alarm_out_n[2];
  endproperty
  a_or: assert property (p_or) else $error("enabled event not on output");

  property p_at_start;
    ce && match && !st.match_q |=> st.at_cnt == AW'(ALARM_CYC);
  endproperty
  a_at_start: assert property (p_at_start) else $error("alarm-time pulse length wrong");

  property p_gm_start;
    ce && st.leader_q[0] && !timing_leader_role[0] |=> st.gm_cnt[0] == GW'(GM_CYC) && st.istat[5];
  endproperty
  a_gm_start: assert property (p_gm_start) else $error("leader loss not caught");

  property p_dly_hold;
    ce && !st.lvl[0] && next_st.lvl[0] |-> cond[0] && (st.dly[0] == '0 || st.dly_sec[0] >= st.dly[0]);
  endproperty
  a_dly_hold: assert property (p_dly_hold) else $error("fault passed before delay");

  property p_dly_clear;
    ce && !cond[1] |=> st.dly_sec[1] == '0 && !st.lvl[1];
  endproperty
  a_dly_clear: assert property (p_dly_clear) else $error("delay timer kept on clear");

  property p_filt_steady;
    ce && (~st.sync2[3] == st.filt[3]) |-> next_st.filt[3] == st.filt[3] && next_st.filt_cnt[3] == '0;
  endproperty
  a_filt_steady: assert property (p_filt_steady) else $error("filter moved without a level change");

  property p_jam;
    ce && !st.filt[2] && next_st.filt[2] && st.action[2] == gcap_pkg::GCAP_ACT_JAM_SYNC |=> jam_sync;
  endproperty
  a_jam: assert property (p_jam) else $error("jam sync not issued");

  property p_recall;
    ce && !st.filt[3] && next_st.filt[3] && st.filt[2:0] == next_st.filt[2:0]
      && st.action[3] == gcap_pkg::GCAP_ACT_RECALL |=> preset_recall && preset_sel == $past(st.preset[3]);
  endproperty
  a_recall: assert property (p_recall) else $error("preset recall wrong");

  property p_lvl_release;
    ce && st.omask[0] == 9'h004 && !st.lvl[1] |=> alarm_out_n[0];
  endproperty
  a_lvl_release: assert property (p_lvl_release) else $error("level alarm held after clear");

  property p_supply;
    ce && st.omask[0][1] && (first_supply_indicator_red || second_supply_indicator_red) |=> !alarm_out_n[0];
  endproperty
  a_supply: assert property (p_supply) else $error("supply fault not on output");

endmodule : gcap_port
`default_nettype wire

// [bench/gcap_contacts.sv]
// contact closures on the command pins and a changeover unit on the alarm pins
// assumes one clock shared with the port under test
`timescale 1ns/1ns
`default_nettype none
module gcap_contacts (
  // clock
  input wire logic clk,
  // pins
  output logic [3:0] cmd_in_n,
  input wire logic [2:0] alarm_out_n
);
  logic [3:0] closed;
  int lowc [3];
  initial closed = 4'h0;
  // ==========================================================
  // contacts
  // open reads high
  assign cmd_in_n = ~closed;
  task automatic hold(input int i, input int n);
    @(posedge clk);
    closed[i] <= 1'b1;
    repeat (n) @(posedge clk);
    closed[i] <= 1'b0;
  endtask : hold
  // ==========================================================
  // changeover unit
  // asserted cycles
  always @(posedge clk) begin
    for (int k = 0; k < 3; k++) begin
      if (alarm_out_n[k] === 1'b0) lowc[k] <= lowc[k] + 1;
    end
  end
  task automatic clr();
    foreach (lowc[k]) lowc[k] = 0;
  endtask : clr
endmodule : gcap_contacts
`default_nettype wire

// [bench/gcap_port_tb_top.sv]
// register-driven test of the auxiliary control port
// assumes the contact model and the constants header
`timescale 1ns/1ns
`default_nettype none
`include "gcap_defines.svh"
module gcap_port_tb_top;
  // ==========================================================
  // signals
  logic clk, rst_n, ce, reg_wr, reg_rd, irq, tod;
  logic [7:0] reg_addr, preset_sel;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] cmd_in_n;
  logic [2:0] alarm_out_n;
  logic [6:0] st;
  logic [1:0] lead;
  logic [4:0] ph, pv;
  logic [5:0] pm, ps;
  int cnt [5];
  int err_count, compares, cyc;
  always #5 clk = ~clk;
  gcap_port #(.FILT_CYC(20), .ALARM_CYC(30), .GM_CYC(10), .SEC_CYC(8)) u_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .cmd_in_n(cmd_in_n), .alarm_out_n(alarm_out_n), .hw_fault(st[0]),
    .first_supply_indicator_red(st[1]), .second_supply_indicator_red(st[2]),
    .ref_red(st[3]), .ref_yellow(st[4]), .time_red(st[5]), .time_yellow(st[6]),
    .timing_leader_role(lead), .prog_hours(ph), .prog_minutes(pm), .prog_seconds(ps),
    .tod_src_internal(tod), .prog_time_reset(pv[0]), .satellite_positioning_receiver_reset(pv[1]),
    .jam_sync(pv[2]), .ntp_update_req(pv[3]), .preset_recall(pv[4]), .preset_sel(preset_sel)
  );
  gcap_contacts u_cont (.clk(clk), .cmd_in_n(cmd_in_n), .alarm_out_n(alarm_out_n));
  // ==========================================================
  // monitors and timeout
  always @(posedge clk) begin
    for (int j = 0; j < 5; j++) begin
      if (pv[j] === 1'b1) cnt[j] <= cnt[j] + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      stop_test();
    end
  end
  // ==========================================================
  // tasks
  task automatic stop_test();
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cka(input logic [31:0] exp);
    chk({29'h0, alarm_out_n}, exp);
  endtask : cka
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic cmd(input int i, input logic [2:0] a, input logic t, input int n, input logic [31:0] exp);
    logic [31:0] g;
    wr(`GCAP_ACTION_OFS, 32'(a) << (3 * i));
    tod <= t;
    foreach (cnt[j]) cnt[j] = 0;
    u_cont.hold(i, n);
    repeat (60) @(posedge clk);
    g = 32'h0;
    foreach (cnt[j]) g[4*j +: 4] = cnt[j][3:0];
    chk(g, exp);
  endtask : cmd
  // ==========================================================
  // sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    st = 7'h00;
    lead = 2'h3;
    ph = 5'h00;
    pm = 6'h00;
    ps = 6'h3B;
    tod = 1'b0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    cka(32'h7);
    rd(`GCAP_ACTION_OFS, 32'h0);
    wr(`GCAP_ACTION_OFS, 32'hFFFFFAD1);
    rd(`GCAP_ACTION_OFS, 32'h00000AD1);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    wr(`GCAP_PRESET_OFS, 32'h07000003);
    // frozen clock enable drops a write
    ce <= 1'b0;
    wr(`GCAP_PRESET_OFS, 32'h0);
    ce <= 1'b1;
    rd(`GCAP_PRESET_OFS, 32'h07000003);
    wr(`GCAP_IMASK_OFS, 32'h1);
    // commands per input
    cmd(0, 3'h1, 1'b0, 10, 32'h0);
    cmd(0, 3'h1, 1'b0, 30, 32'h1);
    cmd(1, 3'h2, 1'b0, 30, 32'h10);
    cmd(2, 3'h3, 1'b0, 30, 32'h100);
    cmd(3, 3'h5, 1'b0, 30, 32'h10000);
    chk({24'h0, preset_sel}, 32'h7);
    cmd(0, 3'h4, 1'b0, 30, 32'h0);
    cmd(0, 3'h4, 1'b1, 30, 32'h1000);
    cmd(0, 3'h0, 1'b1, 30, 32'h0);
    rd(`GCAP_ISTAT_OFS, 32'hF);
    chk({31'h0, irq}, 32'h1);
    wr(`GCAP_ISTAT_OFS, 32'h1);
    rd(`GCAP_ISTAT_OFS, 32'hE);
    chk({31'h0, irq}, 32'h0);
    // alarm pulses and levels
    wr(`GCAP_OMASK0_OFS, 32'h2);
    wr(8'h0C, 32'h80);
    wr(8'h10, 32'h40);
    wr(`GCAP_ATIME_OFS, 32'h00010203);
    u_cont.clr();
    st <= 7'h02;
    lead <= 2'h0;
    ph <= 5'h01;
    pm <= 6'h02;
    ps <= 6'h03;
    repeat (3) @(posedge clk);
    ps <= 6'h04;
    repeat (17) @(posedge clk);
    st <= 7'h04;
    repeat (5) @(posedge clk);
    st <= 7'h00;
    repeat (40) @(posedge clk);
    chk(32'(u_cont.lowc[0]), 32'h19);
    chk(32'(u_cont.lowc[1]), 32'h0A);
    chk(32'(u_cont.lowc[2]), 32'h1E);
    rd(`GCAP_ISTAT_OFS, 32'h7E);
    for (int j = 2; j < 6; j++) begin
      wr(`GCAP_OMASK0_OFS, 32'h1 << j);
      st <= 7'(1 << (j + 1));
      repeat (3) @(posedge clk);
      st <= 7'h00;
      #1;
      cka(32'h6);
      repeat (3) @(posedge clk);
      #1;
      cka(32'h7);
    end
    // delayed hardware fault
    wr(`GCAP_OMASK0_OFS, 32'h1);
    wr(`GCAP_DLY0_OFS, 32'h2);
    st <= 7'h01;
    repeat (10) @(posedge clk);
    st <= 7'h00;
    repeat (2) @(posedge clk);
    st <= 7'h01;
    repeat (10) @(posedge clk);
    #1;
    cka(32'h7);
    repeat (14) @(posedge clk);
    #1;
    cka(32'h6);
    rd(`GCAP_STATUS_OFS, 32'h00000190);
    stop_test();
  end
endmodule : gcap_port_tb_top
`default_nettype wire
